//--- rtl/adcsel_consts.vh
// Constants for the converter select buffer and sleep start block.
// Assumes inclusion by bare name from rtl/ sources; definitions only.
`ifndef ADCSEL_CONSTS_VH
`define ADCSEL_CONSTS_VH

// Register byte addresses on APB
`define ADCSEL_OFS_SELECT     12'h000
`define ADCSEL_OFS_CTRL       12'h004
`define ADCSEL_OFS_RESULT     12'h008
`define ADCSEL_OFS_ACTIVE     12'h00c

// Selection register fields
`define ADCSEL_CH_LSB         0
`define ADCSEL_CH_W           4
`define ADCSEL_REF_LSB        6
`define ADCSEL_REF_W          2
`define ADCSEL_SELECT_RST     8'h00
`define ADCSEL_SELECT_MASK    8'hcf

// Control/status register bits
`define ADCSEL_BIT_PS0        0
`define ADCSEL_BIT_IE         3
`define ADCSEL_BIT_DONE       4
`define ADCSEL_BIT_ATE        5
`define ADCSEL_BIT_START      6
`define ADCSEL_BIT_EN         7
`define ADCSEL_BIT_FREE       8
`define ADCSEL_BIT_IRQ        9
`define ADCSEL_CTRL_RST       10'h000

// Conversion lengths in converter clocks, and the full-scale result code
`define ADCSEL_CONV_NORMAL    5'd13
`define ADCSEL_CONV_FIRST     5'd25
`define ADCSEL_FULL_SCALE     10'h3ff

`endif

//--- rtl/adcsel_sar_core.v
// Successive approximation sequencer: one compare step per converter clock.
// Assumes a comparator input cmp_i settled before each converter tick.
`timescale 1ns/10ps
`include "adcsel_consts.vh"
module adcsel_sar_core #(
    parameter BITS = 10
) (
    input  wire            clk_i,      // System clock
    input  wire            rst_n_i,    // Synchronised reset, active low
    input  wire            ce_i,       // Clock enable
    input  wire            clear_i,    // Abort, converter disabled
    input  wire            load_i,     // Start successive approximation
    input  wire            step_i,     // One converter clock tick
    input  wire            cmp_i,      // Comparator: input above trial level
    output wire [BITS-1:0] trial_o,    // Trial code to the DAC
    output reg  [BITS-1:0] code_o      // Code held after the last step
);
    reg [BITS-1:0] mask_reg;
    reg [BITS-1:0] acc_reg;

    assign trial_o = acc_reg | mask_reg;

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mask_reg <= {BITS{1'b0}};
            acc_reg  <= {BITS{1'b0}};
            code_o   <= {BITS{1'b0}};
        end else if (ce_i) begin
            if (clear_i) begin
                mask_reg <= {BITS{1'b0}};
                acc_reg  <= {BITS{1'b0}};
            end else if (load_i) begin
                mask_reg <= {1'b1, {(BITS-1){1'b0}}};
                acc_reg  <= {BITS{1'b0}};
            end else if (step_i && mask_reg != {BITS{1'b0}}) begin
                // Input above every trial keeps all bits: full scale
                if (cmp_i) begin
                    acc_reg <= acc_reg | mask_reg;
                end
                mask_reg <= mask_reg >> 1;
                if (mask_reg[0]) begin
                    code_o <= cmp_i ? (acc_reg | mask_reg) : acc_reg;
                end
            end
        end
    end
endmodule

//--- rtl/adcsel_top.v
// Converter control: selection buffering, conversion sequencing, sleep start.
// Assumes an APB master on clk_i and an analog front end driven by the outputs.
`timescale 1ns/10ps
`include "adcsel_consts.vh"

// Summary of operation
// - Software selection held in separate holding register
// - Enabled idle converter copies holding to active selection
// - Active selection frozen from conversion start
// - Copying resumes in final converter clock
// - Start begins at next converter clock edge
// - Safe-window selection applies to next conversion
// - Free-running: next conversion takes holding selection copied in final clock
// - Input above reference gives full scale
// - Sleep entry halting CPU starts a conversion only with IE set and ATE clear
// - Early wake still raises completion interrupt
// - CPU stays awake until next sleep
// - Deep sleep leaves converter enable untouched
// - Result and done flag update together
// - Start bit reads one while converting
module adcsel_top #(
    parameter BITS = 10,
    parameter PSW  = 3
) (
    input  wire            clk_i,          // System clock, 10 MHz
    input  wire            arst_n_i,       // Asynchronous reset, active low
    input  wire            ce_i,           // Clock enable, freezes state when low
    input  wire            psel_i,         // APB select
    input  wire            penable_i,      // APB enable
    input  wire            pwrite_i,       // APB write
    input  wire [11:0]     paddr_i,        // APB byte address
    input  wire [31:0]     pwdata_i,       // APB write data
    output wire            pready_o,       // APB ready
    output reg  [31:0]     prdata_o,       // APB read data
    output wire            pslverr_o,      // APB error, unmapped address
    input  wire            trigger_i,      // Auto-trigger source, same clock
    input  wire            sleep_halt_i,   // CPU halted in idle or noise sleep
    input  wire            cmp_i,          // Comparator result from front end
    output reg  [3:0]      input_channel_select_o,   // Active channel
    output reg  [1:0]      reference_source_select_o, // Active reference
    output wire [BITS-1:0] dac_code_o,     // Trial code to the DAC
    output reg             busy_o,         // Conversion in progress
    output reg             irq_o,          // Conversion complete request
    output reg             cpu_wake_o      // Wake pulse to sleep controller
);
    localparam ST_IDLE = 3'b001;
    localparam ST_WAIT = 3'b010;
    localparam ST_CONV = 3'b100;

    reg        rst_a_reg;
    reg        rst_n;
    reg [7:0]  holding_reg;
    reg        enable_reg;
    reg        ate_reg;
    reg        ie_reg;
    reg        done_reg;
    reg        free_reg;
    reg [2:0]  ps_reg;
    reg [PSW+4:0] presc_reg;
    reg [2:0]  state_reg;
    reg [4:0]  cnt_reg;
    reg        first_reg;
    reg        start_req_reg;
    reg        trig_d_reg;
    reg        halt_d_reg;
    reg        sleep_conv_reg;
    reg [BITS-1:0] result_reg;

    wire [BITS-1:0] sar_code;
    wire       wr;
    wire       rd;
    wire       tick;
    wire       last_tick;
    wire       mapped;
    wire       trig_edge;
    wire       sleep_start;
    wire [PSW+4:0] presc_mask;

    function is_mapped;
        input [11:0] a;
        begin
            is_mapped = (a == `ADCSEL_OFS_SELECT) || (a == `ADCSEL_OFS_CTRL) ||
                        (a == `ADCSEL_OFS_RESULT) || (a == `ADCSEL_OFS_ACTIVE);
        end
    endfunction

    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_a_reg <= 1'b0;
            rst_n     <= 1'b0;
        end else begin
            rst_a_reg <= 1'b1;
            rst_n     <= rst_a_reg;
        end
    end

    assign pready_o  = 1'b1;
    assign mapped    = is_mapped(paddr_i);
    assign pslverr_o = psel_i & penable_i & ~mapped;
    assign wr        = psel_i & penable_i & pwrite_i & mapped;
    assign rd        = psel_i & ~penable_i & ~pwrite_i;

    // Prescaled converter clock: divide by 2 to 2^(ps+1)
    assign presc_mask = (({{(PSW+4){1'b0}}, 1'b1} << ps_reg) << 1) -
                        {{(PSW+4){1'b0}}, 1'b1};
    assign tick = enable_reg &&
                  ((presc_reg & presc_mask) == {(PSW+5){1'b0}});
    assign last_tick  = tick && (state_reg == ST_CONV) && (cnt_reg == 5'd1);
    assign trig_edge  = trigger_i & ~trig_d_reg;
    assign sleep_start = sleep_halt_i & ~halt_d_reg & enable_reg & ~busy_o &
                         ~ate_reg & ie_reg;

    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            presc_reg <= {(PSW+5){1'b0}};
        end else if (ce_i) begin
            if (!enable_reg || (ate_reg && trig_edge && !busy_o)) begin
                presc_reg <= {(PSW+5){1'b0}};
            end else begin
                presc_reg <= presc_reg + {{(PSW+4){1'b0}}, 1'b1};
            end
        end
    end

    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            holding_reg <= `ADCSEL_SELECT_RST;
            enable_reg  <= 1'b0;
            ate_reg     <= 1'b0;
            ie_reg      <= 1'b0;
            free_reg    <= 1'b0;
            ps_reg      <= 3'h0;
        end else if (ce_i && wr) begin
            if (paddr_i == `ADCSEL_OFS_SELECT) begin
                holding_reg <= pwdata_i[7:0] & `ADCSEL_SELECT_MASK;
            end
            if (paddr_i == `ADCSEL_OFS_CTRL) begin
                // Deep sleep never touches this bit; only software or reset clears it
                enable_reg <= pwdata_i[`ADCSEL_BIT_EN];
                ate_reg    <= pwdata_i[`ADCSEL_BIT_ATE];
                ie_reg     <= pwdata_i[`ADCSEL_BIT_IE];
                free_reg   <= pwdata_i[`ADCSEL_BIT_FREE];
                ps_reg     <= pwdata_i[2:0];
            end
        end
    end

    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            trig_d_reg <= 1'b0;
            halt_d_reg <= 1'b0;
        end else if (ce_i) begin
            trig_d_reg <= trigger_i;
            halt_d_reg <= sleep_halt_i;
        end
    end

    // Conversion sequencer
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_reg      <= ST_IDLE;
            cnt_reg        <= 5'd0;
            first_reg      <= 1'b1;
            start_req_reg  <= 1'b0;
            busy_o         <= 1'b0;
            done_reg       <= 1'b0;
            result_reg     <= {BITS{1'b0}};
            sleep_conv_reg <= 1'b0;
            irq_o          <= 1'b0;
            cpu_wake_o     <= 1'b0;
        end else if (ce_i) begin
            cpu_wake_o <= 1'b0;
            irq_o      <= done_reg & ie_reg;
            if (wr && paddr_i == `ADCSEL_OFS_CTRL && pwdata_i[`ADCSEL_BIT_DONE]) begin
                done_reg <= 1'b0;
            end
            if (!enable_reg) begin
                state_reg     <= ST_IDLE;
                busy_o        <= 1'b0;
                first_reg     <= 1'b1;
                start_req_reg <= 1'b0;
            end else begin
                case (state_reg)
                    ST_IDLE: begin
                        if ((wr && paddr_i == `ADCSEL_OFS_CTRL &&
                             pwdata_i[`ADCSEL_BIT_START]) || sleep_start ||
                            (ate_reg && trig_edge)) begin
                            state_reg      <= ST_WAIT;
                            busy_o         <= 1'b1;
                            sleep_conv_reg <= sleep_start;
                        end
                    end
                    ST_WAIT: begin
                        if (tick) begin
                            state_reg <= ST_CONV;
                            cnt_reg   <= first_reg ? `ADCSEL_CONV_FIRST
                                                   : `ADCSEL_CONV_NORMAL;
                            first_reg <= 1'b0;
                        end
                    end
                    ST_CONV: begin
                        if (tick) begin
                            cnt_reg <= cnt_reg - 5'd1;
                        end
                        if (last_tick) begin
                            result_reg <= sar_code;
                            done_reg   <= 1'b1;
                            cpu_wake_o <= sleep_conv_reg & ie_reg;
                            sleep_conv_reg <= 1'b0;
                            if (free_reg && ate_reg) begin
                                // Next conversion starts at once on the holding
                                // selection, latched at this same edge
                                cnt_reg <= `ADCSEL_CONV_NORMAL;
                            end else begin
                                state_reg <= ST_IDLE;
                                busy_o    <= 1'b0;
                            end
                        end
                    end
                    default: begin
                        state_reg <= ST_IDLE;
                        busy_o    <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Active selection follows holding register on converter ticks, except mid-conversion
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            input_channel_select_o    <= 4'h0;
            reference_source_select_o <= 2'h0;
        end else if (ce_i && tick) begin
            if (state_reg != ST_CONV || cnt_reg == 5'd1) begin
                input_channel_select_o    <= holding_reg[`ADCSEL_CH_LSB +: `ADCSEL_CH_W];
                reference_source_select_o <= holding_reg[`ADCSEL_REF_LSB +: `ADCSEL_REF_W];
            end
        end
    end

    adcsel_sar_core #(
        .BITS (BITS)
    ) u_sar (
        .clk_i   (clk_i),
        .rst_n_i (rst_n),
        .ce_i    (ce_i),
        .clear_i (~enable_reg),
        // Free running restarts the approximation at the final tick
        .load_i  (tick && (state_reg == ST_WAIT ||
                           (last_tick && free_reg && ate_reg))),
        .step_i  (tick && state_reg == ST_CONV && cnt_reg <= 5'd11),
        .cmp_i   (cmp_i),
        .trial_o (dac_code_o),
        .code_o  (sar_code)
    );

    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            prdata_o <= 32'h0000_0000;
        end else if (ce_i && rd) begin
            case (paddr_i)
                `ADCSEL_OFS_SELECT: prdata_o <= {24'h000000, holding_reg};
                `ADCSEL_OFS_CTRL:   prdata_o <= {22'h0, irq_o, free_reg,
                                                 enable_reg, busy_o, ate_reg,
                                                 done_reg, ie_reg, ps_reg};
                `ADCSEL_OFS_RESULT: prdata_o <= {{(32-BITS){1'b0}}, result_reg};
                `ADCSEL_OFS_ACTIVE: prdata_o <= {24'h000000,
                                                 reference_source_select_o, 2'b00,
                                                 input_channel_select_o};
                default:            prdata_o <= 32'h0000_0000;
            endcase
        end
    end
endmodule

//--- testbench/adc_select_buffer_and_sleep_start_bench.sv
// Self-checking bench for adcsel_top with an APB master and front end model.
// Assumes zero-wait APB and a converter tick every two clocks (prescale 0).
`timescale 1ns/10ps
`include "adcsel_consts.vh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module adc_select_buffer_and_sleep_start_bench;
    localparam [11:0] SEL = `ADCSEL_OFS_SELECT;
    localparam [11:0] CTL = `ADCSEL_OFS_CTRL;
    localparam [11:0] RES = `ADCSEL_OFS_RESULT;
    localparam [11:0] ACT = `ADCSEL_OFS_ACTIVE;
    logic        clk_i = 0, arst_n_i = 0, ce_i = 1, psel_i = 0, penable_i = 0;
    logic        pwrite_i = 0, trigger_i = 0, sleep_halt_i = 0;
    logic [11:0] paddr_i = 0;
    logic [31:0] pwdata_i = 0;
    logic [10:0] level = 0;
    logic [31:0] v;
    logic [32:0] note_q[$];
    integer      bad_count = 0, tests_run = 0, seed = 73, wakes = 0;
    wire         pready_o, pslverr_o, cmp_i, busy_o, irq_o, cpu_wake_o;
    wire [31:0]  prdata_o;
    wire [9:0]   dac_code_o;
    adcsel_top DUT (.clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(ce_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o),
        .trigger_i(trigger_i), .sleep_halt_i(sleep_halt_i), .cmp_i(cmp_i),
        .input_channel_select_o(), .reference_source_select_o(), .dac_code_o(dac_code_o),
        .busy_o(busy_o), .irq_o(irq_o), .cpu_wake_o(cpu_wake_o));
    adcsel_front_model MODEL (.dac_code_i(dac_code_o), .level_i(level), .cmp_o(cmp_i));
    always #50 clk_i = ~clk_i;
    // Read results are matched against the oldest note
    always @(posedge clk_i) if (psel_i && penable_i && pready_o === 1'b1 && !pwrite_i)
        `CHK({pslverr_o, prdata_o}, note_q.pop_front())
    always @(posedge clk_i) if (cpu_wake_o === 1'b1) wakes++;
    task apb(input [11:0] a, input w, input [31:0] d);
        integer n;
        n = 0;
        @(posedge clk_i);
        psel_i <= 1'b1;
        paddr_i <= a;
        pwrite_i <= w;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task rd(input [11:0] a, input [32:0] e);
        note_q.push_back(e);
        apb(a, 1'b0, 32'h0);
    endtask
    task wait_lvl(input integer irq, input b);
        integer n;
        n = 0;
        while ((irq ? irq_o : busy_o) !== b && n < 400) begin
            @(posedge clk_i);
            n++;
        end
        `CHK(irq ? irq_o : busy_o, b)
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_i);
        bad_count++;
        final_report;
    end
    initial begin
        repeat (10) @(posedge clk_i);
        arst_n_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rd(SEL, 33'h0);
        rd(CTL, 33'h0);
        apb(12'h010, 1'b1, 32'hffffffff);
        rd(12'h010, {1'b1, 32'h0});
        apb(ACT, 1'b1, 32'hff);
        rd(ACT, 33'h0);
        apb(CTL, 1'b1, 32'h080);
        repeat (4) begin
            v = $random(seed) & 32'hcf;
            apb(SEL, 1'b1, v);
            rd(SEL, {1'b0, v});
            repeat (4) @(posedge clk_i);
            rd(ACT, {1'b0, v});
        end
        level <= 11'h7ff;
        apb(SEL, 1'b1, 32'h41);
        apb(CTL, 1'b1, 32'h0c8);
        repeat (2) @(posedge clk_i);
        apb(SEL, 1'b1, 32'h8e);
        rd(SEL, 33'h8e);
        rd(ACT, 33'h41);
        rd(CTL, 33'h0c8);
        wait_lvl(0, 1'b0);
        rd(RES, 33'h3ff);
        rd(CTL, 33'h298);
        rd(ACT, 33'h8e);
        level <= 11'h000;
        apb(CTL, 1'b1, 32'h0d8);
        rd(CTL, 33'h0c8);
        wait_lvl(0, 1'b0);
        rd(RES, 33'h0);
        apb(SEL, 1'b1, 32'h03);
        apb(CTL, 1'b1, 32'h1f8);
        wait_lvl(1, 1'b1);
        apb(SEL, 1'b1, 32'hc5);
        rd(ACT, 33'h03);
        apb(CTL, 1'b1, 32'h1f8);
        wait_lvl(1, 1'b0);
        wait_lvl(1, 1'b1);
        rd(ACT, 33'hc5);
        apb(CTL, 1'b1, 32'h000);
        wait_lvl(0, 1'b0);
        apb(CTL, 1'b1, 32'h0b0);
        trigger_i <= 1'b1;
        wait_lvl(0, 1'b1);
        wait_lvl(0, 1'b0);
        trigger_i <= 1'b0;
        apb(CTL, 1'b1, 32'h098);
        sleep_halt_i <= 1'b1;
        wait_lvl(0, 1'b1);
        wait_lvl(0, 1'b0);
        repeat (2) @(posedge clk_i);
        `CHK(wakes, 1)
        apb(CTL, 1'b1, 32'h098);
        repeat (20) @(posedge clk_i);
        `CHK(busy_o, 1'b0)
        sleep_halt_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        sleep_halt_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        sleep_halt_i <= 1'b0;
        wait_lvl(0, 1'b0);
        wait_lvl(1, 1'b1);
        @(posedge clk_i);
        `CHK(wakes, 2)
        apb(CTL, 1'b1, 32'h090);
        sleep_halt_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        `CHK(busy_o, 1'b0)
        final_report;
    end
endmodule
bind adcsel_top adcsel_monitor MON (.clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(ce_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o),
    .sleep_halt_i(sleep_halt_i), .busy_o(busy_o), .irq_o(irq_o), .cpu_wake_o(cpu_wake_o));

//--- testbench/adcsel_front_model.sv
// Analog front end: comparator of the selected input against the trial code.
// Assumes level_i of 2**BITS or more means an input above the reference.
`timescale 1ns/10ps
module adcsel_front_model #(
    parameter BITS = 10
) (
    input  wire [BITS-1:0] dac_code_i, // Trial code
    input  wire [BITS:0]   level_i,    // Input level in codes
    output wire            cmp_o       // Input above trial level
);
    assign cmp_o = {1'b0, dac_code_i} < level_i;
endmodule

//--- testbench/adcsel_top_monitor.sv
// Concurrent checks on the converter control block, bound to adcsel_top.
// Assumes one clk_i domain and the APB offsets of adcsel_consts.vh.
`timescale 1ns/10ps
`include "adcsel_consts.vh"
module adcsel_monitor (
    input wire        clk_i,        // Clock
    input wire        arst_n_i,     // Reset
    input wire        ce_i,         // Enable
    input wire        psel_i,       // APB
    input wire        penable_i,    // APB
    input wire        pwrite_i,     // APB
    input wire [11:0] paddr_i,      // APB
    input wire [31:0] pwdata_i,     // APB
    input wire        pready_o,     // APB
    input wire [31:0] prdata_o,     // APB
    input wire        pslverr_o,    // APB
    input wire        sleep_halt_i, // Sleep
    input wire        busy_o,       // Busy
    input wire        irq_o,        // Request
    input wire        cpu_wake_o    // Wake
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    reg  [7:0] hold_reg;
    reg        ie_reg;
    reg        en_reg;
    reg        ate_reg;
    wire       acc = psel_i && penable_i && ce_i;
    wire       mapped = paddr_i[11:4] == 8'h00 && paddr_i[1:0] == 2'h0;
    wire       wr_ctl = acc && pwrite_i && paddr_i == `ADCSEL_OFS_CTRL;
    // Shadow of software-visible state
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            hold_reg <= 8'h00;
            ie_reg   <= 1'b0;
            en_reg   <= 1'b0;
            ate_reg  <= 1'b0;
        end else begin
            if (acc && pwrite_i && paddr_i == `ADCSEL_OFS_SELECT)
                hold_reg <= pwdata_i[7:0] & `ADCSEL_SELECT_MASK;
            if (wr_ctl) begin
                ie_reg  <= pwdata_i[3];
                en_reg  <= pwdata_i[7];
                ate_reg <= pwdata_i[5];
            end
        end
    end
    sequence s_start_wr;
        wr_ctl && pwdata_i[7] && pwdata_i[6] && !busy_o;
    endsequence
    sequence s_sleep_entry;
        $rose(sleep_halt_i) && en_reg && ie_reg && !ate_reg && !busy_o && ce_i;
    endsequence
    ready_high_a: assert property (pready_o) else $error("pready low");
    err_map_a: assert property (acc |-> pslverr_o == !mapped) else $error("slverr wrong");
    unmapped_zero_a: assert property (acc && !mapped && !pwrite_i |-> prdata_o == 32'h0)
        else $error("unmapped read not zero");
    sel_read_a: assert property (acc && !pwrite_i && paddr_i == `ADCSEL_OFS_SELECT
        |-> prdata_o == {24'h0, hold_reg}) else $error("select read wrong");
    busy_read_a: assert property (acc && !pwrite_i && paddr_i == `ADCSEL_OFS_CTRL
        |-> prdata_o[6] == $past(busy_o)) else $error("start bit read wrong");
    start_busy_a: assert property (s_start_wr |=> busy_o) else $error("no start");
    sleep_start_a: assert property (s_sleep_entry |-> ##[1:3] busy_o)
        else $error("no sleep start");
    irq_done_a: assert property ($fell(busy_o) && ie_reg && en_reg |-> ##[0:2] irq_o)
        else $error("no completion request");
    wake_pulse_a: assert property (cpu_wake_o |=> !cpu_wake_o) else $error("wake long");
    wake_end_a: assert property (cpu_wake_o |-> !busy_o && ($past(busy_o) || $past(busy_o, 2)))
        else $error("wake not at end");
endmodule
